/* File: design/overtemp_cfg_pkg.sv */
package overtemp_cfg_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_CH = 3;
  localparam int NUM_FAN = 3;
  localparam int NUM_RAIL = 4;

  // ************************************************************
  // Register indices and byte addresses
  // ************************************************************
  localparam logic [ADDR_W-1:0] IDX_PIN_CFG = 12'h07D;
  localparam logic [ADDR_W-1:0] IDX_TEST_ONE = 12'h07E;
  localparam logic [ADDR_W-1:0] IDX_TEST_TWO = 12'h07F;
  localparam logic [ADDR_W-1:0] ADDR_PIN_CFG = IDX_PIN_CFG << 2;
  localparam logic [ADDR_W-1:0] ADDR_TEST_ONE = IDX_TEST_ONE << 2;
  localparam logic [ADDR_W-1:0] ADDR_TEST_TWO = IDX_TEST_TWO << 2;
  localparam logic [ADDR_W-1:0] ADDR_CONTROL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_OT_LIMIT = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_FAN_MAX = 12'h008;
  localparam logic [ADDR_W-1:0] ADDR_TEMP = 12'h00C;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h010;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int CTRL_LOCK_BIT = 0;
  localparam int CTRL_FORMAT_BIT = 1;
  localparam int STAT_PIN_LEVEL_BIT = 4;
  localparam int STAT_ASSERTED_BIT = 3;

  // ************************************************************
  // Reset values and fixed codes
  // ************************************************************
  localparam logic [7:0] PIN_CFG_RESET = 8'h00;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [7:0] CONTROL_RESET = 8'h02;
  localparam logic [7:0] OT_LIMIT_RESET = 8'h64;
  localparam logic [7:0] FAN_MAX_RESET = 8'hFF;
  localparam logic [7:0] FAN_FULL_SPEED = 8'hFF;
  localparam logic [7:0] OT_OFF_OFFSET64 = 8'h00;
  localparam logic [7:0] OT_OFF_TWOS = 8'h80;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    ROLE_TACH     = 2'b00,
    ROLE_OVERTEMP = 2'b01,
    ROLE_ALERT    = 2'b10,
    ROLE_GPIO     = 2'b11
  } pin_role_e;

  typedef struct packed {
    logic                twelve_volt_attenuator_bypass;
    logic                five_volt_attenuator_bypass;
    logic                core_rail_attenuator_bypass;
    logic                low_rail_attenuator_bypass;
    logic                overtemp_fan_target_select;
    logic                overtemp_output_kill;
    pin_role_e           shared_pin_role_select;
  } pin_cfg_s;

  typedef enum {
    SEL_NONE,
    SEL_PIN_CFG,
    SEL_TEST_ONE,
    SEL_TEST_TWO,
    SEL_CONTROL,
    SEL_OT_LIMIT,
    SEL_FAN_MAX,
    SEL_TEMP,
    SEL_STATUS
  } reg_sel_e;

endpackage

/* File: design/overtemp_channel_check.sv */
`timescale 1ns/100ps
module overtemp_channel_check
  import overtemp_cfg_pkg::*;
(
  input  wire logic [7:0] temp_i,
  input  wire logic [7:0] limit_i,
  input  wire logic       twos_format_i,
  output logic            exceeded_o
);

  logic off_code;
  logic above;

  // Limit at the format's minimum switches the channel off
  assign off_code = twos_format_i ? (limit_i == OT_OFF_TWOS) : (limit_i == OT_OFF_OFFSET64);

  // Signed compare in twos complement, unsigned in offset-64
  assign above = twos_format_i ? ($signed(temp_i) > $signed(limit_i)) : (temp_i > limit_i);

  assign exceeded_o = above && !off_code;

endmodule

/* File: design/overtemp_pin_config_regs.sv */
`timescale 1ns/100ps
module overtemp_pin_config_regs
  import overtemp_cfg_pkg::*;
(
  input  wire logic                          sys_clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic [ADDR_W-1:0]             s_axi_awaddr_i,
  input  wire logic                          s_axi_awvalid_i,
  output logic                               s_axi_awready_o,
  input  wire logic [DATA_W-1:0]             s_axi_wdata_i,
  input  wire logic [DATA_W/8-1:0]           s_axi_wstrb_i,
  input  wire logic                          s_axi_wvalid_i,
  output logic                               s_axi_wready_o,
  output logic [1:0]                         s_axi_bresp_o,
  output logic                               s_axi_bvalid_o,
  input  wire logic                          s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]             s_axi_araddr_i,
  input  wire logic                          s_axi_arvalid_i,
  output logic                               s_axi_arready_o,
  output logic [DATA_W-1:0]                  s_axi_rdata_o,
  output logic [1:0]                         s_axi_rresp_o,
  output logic                               s_axi_rvalid_o,
  input  wire logic                          s_axi_rready_i,
  input  wire logic [NUM_CH-1:0][7:0]        temp_reading_i,
  input  wire logic                          overtemp_pin_i,
  output logic                               overtemp_pin_out_o,
  output logic                               overtemp_pin_oe_n_o,
  output logic                               shared_pin_out_o,
  output logic                               shared_pin_oe_n_o,
  output logic [1:0]                         shared_pin_role_o,
  output logic                               fan4_tach_enable_o,
  output logic                               fan_override_o,
  output logic [NUM_FAN-1:0][7:0]            fan_target_o,
  output logic [NUM_RAIL-1:0]                attenuator_bypass_o
);

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic reg_sel_e decode(input logic [ADDR_W-1:0] addr);
    reg_sel_e sel;
    sel = SEL_NONE;
    unique case ({addr[ADDR_W-1:2], 2'b00})
      ADDR_PIN_CFG:  sel = SEL_PIN_CFG;
      ADDR_TEST_ONE: sel = SEL_TEST_ONE;
      ADDR_TEST_TWO: sel = SEL_TEST_TWO;
      ADDR_CONTROL:  sel = SEL_CONTROL;
      ADDR_OT_LIMIT: sel = SEL_OT_LIMIT;
      ADDR_FAN_MAX:  sel = SEL_FAN_MAX;
      ADDR_TEMP:     sel = SEL_TEMP;
      ADDR_STATUS:   sel = SEL_STATUS;
      default:       sel = SEL_NONE;
    endcase
    return sel;
  endfunction

  // ************************************************************
  // Storage
  // ************************************************************
  pin_cfg_s                  pin_cfg;
  logic [7:0]                test_one;
  logic [7:0]                test_two;
  logic                      cfg_lock;
  logic                      temp_format_select;
  logic [NUM_CH-1:0][7:0]    ot_limit;
  logic [NUM_FAN-1:0][7:0]   fan_max;
  logic [NUM_CH-1:0]         exceeded;
  logic [NUM_CH-1:0]         exceeded_q;
  logic                      overtemp_active;
  logic                      pin_level;

  // ************************************************************
  // Write channel
  // ************************************************************
  logic                      aw_full;
  logic                      w_full;
  logic [ADDR_W-1:0]         aw_addr;
  logic [DATA_W-1:0]         w_data;
  logic [DATA_W/8-1:0]       w_strb;
  logic                      do_write;
  reg_sel_e                  wr_sel;

  assign do_write = aw_full && w_full && !s_axi_bvalid_o;
  assign wr_sel   = decode(aw_addr);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      aw_full         <= 1'b0;
      aw_addr         <= '0;
      s_axi_awready_o <= 1'b0;
    end else if (s_axi_awvalid_i && s_axi_awready_o) begin
      aw_full         <= 1'b1;
      aw_addr         <= s_axi_awaddr_i;
      s_axi_awready_o <= 1'b0;
    end else if (do_write) begin
      aw_full <= 1'b0;
    end else if (!aw_full && !s_axi_bvalid_o) begin
      s_axi_awready_o <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      w_full         <= 1'b0;
      w_data         <= '0;
      w_strb         <= '0;
      s_axi_wready_o <= 1'b0;
    end else if (s_axi_wvalid_i && s_axi_wready_o) begin
      w_full         <= 1'b1;
      w_data         <= s_axi_wdata_i;
      w_strb         <= s_axi_wstrb_i;
      s_axi_wready_o <= 1'b0;
    end else if (do_write) begin
      w_full <= 1'b0;
    end else if (!w_full && !s_axi_bvalid_o) begin
      s_axi_wready_o <= 1'b1;
    end
  end

  // Refused writes still answer OKAY; only unmapped space errors
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  // ************************************************************
  // Register updates
  // ************************************************************
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pin_cfg <= pin_cfg_s'(PIN_CFG_RESET);
    end else if (do_write && wr_sel == SEL_PIN_CFG && w_strb[0] && !cfg_lock) begin
      pin_cfg <= pin_cfg_s'(w_data[7:0]);
    end
  end

  // Lock only sets; cleared by reset alone
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg_lock           <= CONTROL_RESET[CTRL_LOCK_BIT];
      temp_format_select <= CONTROL_RESET[CTRL_FORMAT_BIT];
    end else if (do_write && wr_sel == SEL_CONTROL && w_strb[0]) begin
      cfg_lock           <= cfg_lock | w_data[CTRL_LOCK_BIT];
      temp_format_select <= w_data[CTRL_FORMAT_BIT];
    end
  end

  // Test registers have no write path
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      test_one <= TEST_RESET;
      test_two <= TEST_RESET;
    end else begin
      test_one <= test_one;
      test_two <= test_two;
    end
  end

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_limit
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          ot_limit[i] <= OT_LIMIT_RESET;
        end else if (do_write && wr_sel == SEL_OT_LIMIT && w_strb[i]) begin
          ot_limit[i] <= w_data[8*i +: 8];
        end
      end
    end
    for (genvar f = 0; f < NUM_FAN; f++) begin : g_fan_max
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          fan_max[f] <= FAN_MAX_RESET;
        end else if (do_write && wr_sel == SEL_FAN_MAX && w_strb[f]) begin
          fan_max[f] <= w_data[8*f +: 8];
        end
      end
    end
  endgenerate

  // ************************************************************
  // Overtemperature evaluation
  // ************************************************************
  generate
    for (genvar c = 0; c < NUM_CH; c++) begin : g_check
      overtemp_channel_check i_overtemp_channel_check (
        .temp_i        (temp_reading_i[c]),
        .limit_i       (ot_limit[c]),
        .twos_format_i (temp_format_select),
        .exceeded_o    (exceeded[c])
      );
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      exceeded_q      <= '0;
      overtemp_active <= 1'b0;
      pin_level       <= 1'b1;
    end else begin
      exceeded_q      <= exceeded;
      overtemp_active <= (|exceeded) && !pin_cfg.overtemp_output_kill;
      pin_level       <= overtemp_pin_i;
    end
  end

  // Open-drain, active low: drive low while asserted
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      overtemp_pin_out_o  <= 1'b0;
      overtemp_pin_oe_n_o <= 1'b1;
      shared_pin_out_o    <= 1'b0;
      shared_pin_oe_n_o   <= 1'b1;
    end else begin
      overtemp_pin_out_o  <= 1'b0;
      overtemp_pin_oe_n_o <= !overtemp_active;
      shared_pin_out_o    <= 1'b0;
      shared_pin_oe_n_o   <= !(overtemp_active && pin_cfg.shared_pin_role_select == ROLE_OVERTEMP);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      shared_pin_role_o   <= ROLE_TACH;
      fan4_tach_enable_o  <= 1'b1;
      attenuator_bypass_o <= '0;
    end else begin
      shared_pin_role_o   <= pin_cfg.shared_pin_role_select;
      fan4_tach_enable_o  <= (pin_cfg.shared_pin_role_select == ROLE_TACH);
      attenuator_bypass_o <= {pin_cfg.twelve_volt_attenuator_bypass, pin_cfg.five_volt_attenuator_bypass,
                              pin_cfg.core_rail_attenuator_bypass, pin_cfg.low_rail_attenuator_bypass};
    end
  end

  generate
    for (genvar f = 0; f < NUM_FAN; f++) begin : g_fan_out
      always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
          fan_target_o[f] <= FAN_FULL_SPEED;
        end else if (pin_cfg.overtemp_fan_target_select) begin
          fan_target_o[f] <= fan_max[f];
        end else begin
          fan_target_o[f] <= FAN_FULL_SPEED;
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      fan_override_o <= 1'b0;
    end else begin
      fan_override_o <= |exceeded;
    end
  end

  // ************************************************************
  // Read channel
  // ************************************************************
  reg_sel_e                  rd_sel;
  logic [DATA_W-1:0]         rd_word;

  assign rd_sel = decode(s_axi_araddr_i);

  always_comb begin
    rd_word = '0;
    unique case (rd_sel)
      SEL_PIN_CFG:  rd_word[7:0] = pin_cfg;
      SEL_TEST_ONE: rd_word[7:0] = test_one;
      SEL_TEST_TWO: rd_word[7:0] = test_two;
      SEL_CONTROL: begin
        rd_word[CTRL_LOCK_BIT]   = cfg_lock;
        rd_word[CTRL_FORMAT_BIT] = temp_format_select;
      end
      SEL_OT_LIMIT: rd_word[8*NUM_CH-1:0] = ot_limit;
      SEL_FAN_MAX:  rd_word[8*NUM_FAN-1:0] = fan_max;
      SEL_TEMP:     rd_word[8*NUM_CH-1:0] = temp_reading_i;
      SEL_STATUS: begin
        rd_word[NUM_CH-1:0]         = exceeded_q;
        rd_word[STAT_ASSERTED_BIT]  = overtemp_active;
        rd_word[STAT_PIN_LEVEL_BIT] = pin_level;
      end
      SEL_NONE:     rd_word = '0;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b0;
      s_axi_rdata_o   <= '0;
      s_axi_rresp_o   <= RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o  <= 1'b1;
      s_axi_rdata_o   <= rd_word;
      s_axi_rresp_o   <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end else if (!s_axi_rvalid_o) begin
      s_axi_arready_o <= 1'b1;
    end
  end

endmodule

/* File: dv/overtemp_cfg_monitor.sv */
`timescale 1ns/100ps
module overtemp_cfg_monitor
  import overtemp_cfg_pkg::*;
(
  input wire logic                    sys_clk_i,
  input wire logic                    rst_n_i,
  input wire logic                    s_axi_awvalid_i,
  input wire logic                    s_axi_awready_o,
  input wire logic                    s_axi_wvalid_i,
  input wire logic                    s_axi_wready_o,
  input wire logic [1:0]              s_axi_bresp_o,
  input wire logic                    s_axi_bvalid_o,
  input wire logic                    s_axi_bready_i,
  input wire logic [ADDR_W-1:0]       s_axi_araddr_i,
  input wire logic                    s_axi_arvalid_i,
  input wire logic                    s_axi_arready_o,
  input wire logic [DATA_W-1:0]       s_axi_rdata_o,
  input wire logic [1:0]              s_axi_rresp_o,
  input wire logic                    s_axi_rvalid_o,
  input wire logic                    s_axi_rready_i,
  input wire logic                    overtemp_pin_out_o,
  input wire logic                    overtemp_pin_oe_n_o,
  input wire logic                    shared_pin_out_o,
  input wire logic                    shared_pin_oe_n_o,
  input wire logic [1:0]              shared_pin_role_o,
  input wire logic                    fan4_tach_enable_o,
  input wire logic [NUM_FAN-1:0][7:0] fan_target_o,
  input wire logic [NUM_RAIL-1:0]     attenuator_bypass_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [ADDR_W-1:0] rd_addr;
  // ****************************************
  // Address of the read under way
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (s_axi_arvalid_i && s_axi_arready_o) begin
      rd_addr <= s_axi_araddr_i;
    end
  end
  chk_bresp_stays: assert property (
    s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp dropped");
  chk_write_answer: assert property (
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o |-> ##2 s_axi_bvalid_o)
    else $error("no write response");
  chk_read_answer: assert property (
    s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o) else $error("no read response");
  chk_rdata_stays: assert property (
    s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata dropped");
  chk_test_zero: assert property (
    s_axi_rvalid_o && (rd_addr[ADDR_W-1:2] == IDX_TEST_ONE[9:0] || rd_addr[ADDR_W-1:2] == IDX_TEST_TWO[9:0])
    |-> s_axi_rdata_o == '0 && s_axi_rresp_o == RESP_OKAY) else $error("test register not zero");
  chk_tach_role: assert property (
    fan4_tach_enable_o == (shared_pin_role_o == 2'b00)) else $error("tach enable wrong for role");
  chk_shared_drive: assert property (
    !shared_pin_oe_n_o |-> shared_pin_role_o == 2'b01 && !shared_pin_out_o) else $error("shared pin driven");
  chk_pin_open_drain: assert property (
    !overtemp_pin_oe_n_o |-> !overtemp_pin_out_o) else $error("overtemp pin driven high");
  chk_reset_state: assert property (
    $rose(rst_n_i) |-> !s_axi_bvalid_o && !s_axi_rvalid_o && attenuator_bypass_o == '0 && fan4_tach_enable_o
    && fan_target_o == {NUM_FAN{FAN_FULL_SPEED}}) else $error("reset state wrong");
endmodule

bind overtemp_pin_config_regs overtemp_cfg_monitor i_overtemp_cfg_monitor (.*);

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
module tb_top
  import overtemp_cfg_pkg::*;
();
  logic                    sys_clk_i, rst_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
  logic                    s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o;
  logic                    s_axi_rready_i, overtemp_pin_i, overtemp_pin_out_o, overtemp_pin_oe_n_o;
  logic                    shared_pin_out_o, shared_pin_oe_n_o, fan4_tach_enable_o, fan_override_o;
  logic [ADDR_W-1:0]       s_axi_awaddr_i, s_axi_araddr_i;
  logic [DATA_W-1:0]       s_axi_wdata_i, s_axi_rdata_o;
  logic [3:0]              s_axi_wstrb_i;
  logic [1:0]              s_axi_bresp_o, s_axi_rresp_o, shared_pin_role_o;
  logic [NUM_CH-1:0][7:0]  temp_reading_i;
  logic [NUM_FAN-1:0][7:0] fan_target_o;
  logic [NUM_RAIL-1:0]     attenuator_bypass_o;
  logic [1:0]              wq[$];
  logic [33:0]             rq[$];
  int                      miscompares, check_count, cycles;

  overtemp_pin_config_regs i_overtemp_pin_config_regs (.*);

  initial begin
    sys_clk_i = 1'b0;
    forever #50 sys_clk_i = ~sys_clk_i;
  end
  // ****************************************
  // Compare, report and bus tasks
  // ****************************************
  task automatic cmp_bus(input string what, input logic [33:0] exp, input logic [33:0] got);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_port(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_bus(what, {2'b00, exp}, {2'b00, got});
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic settle;
    repeat (4) @(posedge sys_clk_i);
    @(negedge sys_clk_i);
  endtask
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
    logic da, dw;
    da = 1'b0;
    dw = 1'b0;
    wq.push_back(r);
    @(posedge sys_clk_i);
    s_axi_awaddr_i  <= a;
    s_axi_wdata_i   <= d;
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i  <= 1'b1;
    s_axi_bready_i  <= 1'b1;
    while (!(da && dw)) begin
      @(negedge sys_clk_i);
      da = da || s_axi_awready_o;
      dw = dw || s_axi_wready_o;
      @(posedge sys_clk_i);
      if (da) s_axi_awvalid_i <= 1'b0;
      if (dw) s_axi_wvalid_i <= 1'b0;
    end
    @(negedge sys_clk_i);
    while (!s_axi_bvalid_o) @(negedge sys_clk_i);
    @(posedge sys_clk_i);
    s_axi_bready_i <= 1'b0;
  endtask
  task automatic axi_rd(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] r);
    rq.push_back({r, d});
    @(posedge sys_clk_i);
    s_axi_araddr_i  <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i  <= 1'b1;
    @(negedge sys_clk_i);
    while (!s_axi_arready_o) @(negedge sys_clk_i);
    @(posedge sys_clk_i);
    s_axi_arvalid_i <= 1'b0;
    @(negedge sys_clk_i);
    while (!s_axi_rvalid_o) @(negedge sys_clk_i);
    @(posedge sys_clk_i);
    s_axi_rready_i <= 1'b0;
  endtask
  // ****************************************
  // Response watcher and timeout
  // ****************************************
  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (s_axi_bvalid_o && s_axi_bready_i) begin
      cmp_bus("bresp", {wq.pop_front(), 32'h0000_0000}, {s_axi_bresp_o, 32'h0000_0000});
    end
    if (s_axi_rvalid_o && s_axi_rready_i) begin
      cmp_bus("read", rq.pop_front(), {s_axi_rresp_o, s_axi_rdata_o});
    end
    if (cycles == 6000) begin
      miscompares++;
      test_done();
    end
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    logic [7:0]  b;
    logic [23:0] f;
    {rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
    {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, overtemp_pin_i} = '0;
    s_axi_wstrb_i = 4'hF;
    b = 8'($urandom(32'hd2fb21b2));
    temp_reading_i = 24'($urandom);
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    axi_rd(ADDR_PIN_CFG, 32'h0000_0000, RESP_OKAY);
    axi_rd(ADDR_TEST_ONE, 32'h0000_0000, RESP_OKAY);
    axi_rd(ADDR_TEST_TWO, 32'h0000_0000, RESP_OKAY);
    settle();
    cmp_port("fan_target", {8'h00, {3{FAN_FULL_SPEED}}}, {8'h00, fan_target_o});
    $display("test reset_values done");
    for (int r = 0; r < 4; r++) begin
      b = {4'($urandom), 2'b00, 2'(r)};
      overtemp_pin_i <= 1'($urandom);
      axi_wr(ADDR_PIN_CFG, {24'h00_0000, b}, RESP_OKAY);
      axi_rd(ADDR_PIN_CFG, {24'h00_0000, b}, RESP_OKAY);
      settle();
      cmp_port("role", 32'(r), {30'h0, shared_pin_role_o});
      cmp_port("bypass", {28'h000_0000, b[7:4]}, {28'h000_0000, attenuator_bypass_o});
    end
    $display("test pin_roles done");
    f = 24'($urandom);
    axi_wr(ADDR_FAN_MAX, {8'h00, f}, RESP_OKAY);
    axi_wr(ADDR_OT_LIMIT, 32'h0010_1010, RESP_OKAY);
    temp_reading_i <= {3{8'h30}};
    axi_wr(ADDR_PIN_CFG, 32'h0000_0001, RESP_OKAY);
    settle();
    cmp_port("override", 32'h0000_0001, {31'h0, fan_override_o});
    axi_rd(ADDR_STATUS, {27'h000_0000, overtemp_pin_i, 4'hF}, RESP_OKAY);
    axi_rd(ADDR_TEMP, {8'h00, {3{8'h30}}}, RESP_OKAY);
    cmp_port("fan_full", {8'h00, {3{FAN_FULL_SPEED}}}, {8'h00, fan_target_o});
    cmp_port("shared_oe_n", 32'h0000_0000, {31'h0, shared_pin_oe_n_o});
    axi_wr(ADDR_PIN_CFG, 32'h0000_000D, RESP_OKAY);
    settle();
    cmp_port("fan_max", {8'h00, f}, {8'h00, fan_target_o});
    cmp_port("shared_oe_n", 32'h0000_0001, {31'h0, shared_pin_oe_n_o});
    cmp_port("pin_oe_n", 32'h0000_0001, {31'h0, overtemp_pin_oe_n_o});
    $display("test fan_target_kill done");
    axi_wr(ADDR_OT_LIMIT, {8'h00, {3{OT_OFF_TWOS}}}, RESP_OKAY);
    temp_reading_i <= {3{8'hC0}};
    settle();
    cmp_port("override_twos_off", 32'h0000_0000, {31'h0, fan_override_o});
    axi_wr(ADDR_CONTROL, 32'h0000_0000, RESP_OKAY);
    settle();
    cmp_port("override_80_off64", 32'h0000_0001, {31'h0, fan_override_o});
    axi_wr(ADDR_OT_LIMIT, {8'h00, {3{OT_OFF_OFFSET64}}}, RESP_OKAY);
    temp_reading_i <= {3{8'hFF}};
    settle();
    cmp_port("override_off64_off", 32'h0000_0000, {31'h0, fan_override_o});
    axi_wr(ADDR_OT_LIMIT, 32'h0001_0101, RESP_OKAY);
    temp_reading_i <= {3{8'h90}};
    settle();
    cmp_port("override_unsigned", 32'h0000_0001, {31'h0, fan_override_o});
    axi_wr(ADDR_CONTROL, 32'h0000_0002, RESP_OKAY);
    settle();
    cmp_port("override_signed", 32'h0000_0000, {31'h0, fan_override_o});
    $display("test limit_format done");
    axi_wr(ADDR_TEST_ONE, 32'hFFFF_FFFF, RESP_OKAY);
    axi_wr(ADDR_TEST_TWO, 32'hFFFF_FFFF, RESP_OKAY);
    axi_rd(ADDR_TEST_ONE, 32'h0000_0000, RESP_OKAY);
    axi_rd(ADDR_TEST_TWO, 32'h0000_0000, RESP_OKAY);
    axi_wr(12'h100, 32'hFFFF_FFFF, RESP_SLVERR);
    axi_rd(12'h100, 32'h0000_0000, RESP_SLVERR);
    $display("test read_only_unmapped done");
    b = 8'($urandom);
    axi_wr(ADDR_PIN_CFG, {24'h00_0000, b}, RESP_OKAY);
    axi_wr(ADDR_CONTROL, 32'h0000_0003, RESP_OKAY);
    axi_wr(ADDR_PIN_CFG, {24'h00_0000, ~b}, RESP_OKAY);
    axi_rd(ADDR_PIN_CFG, {24'h00_0000, b}, RESP_OKAY);
    settle();
    cmp_port("locked_role", {30'h0, b[1:0]}, {30'h0, shared_pin_role_o});
    $display("test lock done");
    test_done();
  end
endmodule
